// file: hdl/csbu_defines.vh
// constants for the compare, skip and branch unit
`ifndef CSBU_DEFINES_VH
`define CSBU_DEFINES_VH
`define CSBU_OP_NONE 4'h0
`define CSBU_OP_CMPSKIP 4'h1
`define CSBU_OP_CMPI 4'h2
`define CSBU_OP_SKRC 4'h3
`define CSBU_OP_SKRS 4'h4
`define CSBU_OP_SKIC 4'h5
`define CSBU_OP_SKIS 4'h6
`define CSBU_OP_BRFS 4'h7
`define CSBU_OP_BRFC 4'h8
`define CSBU_OP_SIGGE 4'h9
`define CSBU_OP_SIGLT 4'hA
`define CSBU_FLAG_C 3'h0
`define CSBU_FLAG_Z 3'h1
`define CSBU_FLAG_N 3'h2
`define CSBU_FLAG_V 3'h3
`define CSBU_FLAG_S 3'h4
`define CSBU_FLAG_H 3'h5
`define CSBU_FLAG_T 3'h6
`define CSBU_FLAG_I 3'h7
`define CSBU_WAIT_NONE 2'h0
`define CSBU_WAIT_ONE 2'h1
`define CSBU_WAIT_TWO 2'h2
`define CSBU_SKIP_SHORT 2'h2
`define CSBU_SKIP_LONG 2'h3
`define CSBU_ST_IDLE 2'h0
`define CSBU_ST_WAIT 2'h1
`endif

// file: hdl/csbu_flag_select.v
// picks one status bit by index and compares it with the wanted level
`timescale 1ns/10ps
module csbu_flag_select
#(
  parameter WIDTH = 8
)
(
  input wire [WIDTH-1:0] flags,
  input wire [2:0] index,
  input wire wantSet,
  output wire hit
);
  assign hit = (flags[index] == wantSet);
endmodule

// file: hdl/csbu_compare_sub.v
// register minus operand with the five compare flags
`timescale 1ns/10ps
module csbu_compare_sub
(
  input wire [7:0] lhs,
  input wire [7:0] rhs,
  output wire [7:0] diff,
  output wire carry,
  output wire half,
  output wire overflow,
  output wire zero,
  output wire negative
);
  wire [8:0] full;
  wire [4:0] low;
  assign full = {1'b0, lhs} - {1'b0, rhs};
  assign low = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]};
  assign diff = full[7:0];
  assign carry = full[8];
  assign half = low[4];
  assign overflow = (lhs[7] & ~rhs[7] & ~diff[7]) | (~lhs[7] & rhs[7] & diff[7]);
  assign zero = (diff == 8'h00);
  assign negative = diff[7];
endmodule

// file: hdl/csbu_unit.v
// compare, skip and branch control of the 8-bit core
// Function
// - compare_skip_equal skips next instruction when two registers match, no flags
// - compare_with_immediate subtracts constant, updates Z N V C H S, one cycle
// - skip_reg_bit_clear skips next instruction when register bit is zero
// - skip_reg_bit_set skips next instruction when register bit is one
// - skip_io_bit_clear skips when I/O bit is zero, flags kept
// - skip_io_bit_set skips when I/O bit is one, flags kept
// - branch_flag_set jumps to pc plus offset plus one when indexed bit set
// - branch_flag_clear jumps to pc plus offset plus one when indexed bit clear
// - carry clear and carry set branches test carry, one or two cycles
// - same_or_higher branches on carry zero, lower on carry one
// - signed_ge branches when negative xor overflow is zero
// - signed_lt branches when negative xor overflow is one
// - halfcarry_set branches when half carry is one
// - halfcarry_clear branches when half carry is zero
// - transfer_set branches when transfer bit is one
// - transfer_clear branches when transfer bit is zero
// - overflow_set branches when overflow is one
// - overflow_clear branches when overflow is zero
`timescale 1ns/10ps
`include "csbu_defines.vh"
module csbu_unit
#(
  parameter PC_WIDTH = 12
)
(
  input wire sys_clk,
  input wire reset_n,
  input wire clkEn,
  input wire opValid,
  input wire [3:0] opCode,
  input wire [7:0] regA,
  input wire [7:0] regB,
  input wire [7:0] immValue,
  input wire [7:0] ioValue,
  input wire [2:0] bitIndex,
  input wire [6:0] branchOffset,
  input wire nextIsTwoWord,
  input wire [PC_WIDTH-1:0] pcIn,
  input wire [7:0] statusIn,
  output reg busy,
  output reg pcLoad,
  output reg [PC_WIDTH-1:0] pcNext,
  output reg flagsLoad,
  output reg [7:0] statusOut,
  output reg done
);
  wire [7:0] diff;
  wire subC;
  wire subH;
  wire subV;
  wire subZ;
  wire subN;
  wire flagHit;
  wire signedLess;
  wire [PC_WIDTH-1:0] offsetExt;
  reg [1:0] state;
  reg [1:0] waitCount;
  reg [1:0] next_waitCount;
  reg next_pcLoad;
  reg [PC_WIDTH-1:0] next_pcNext;
  reg next_flagsLoad;
  reg [7:0] next_statusOut;
  reg skipHit;
  reg selSet;
  wire regBit;
  wire ioBit;
  wire carryFlag;
  wire zeroFlag;
  wire negFlag;
  wire ovfFlag;
  wire signFlag;
  wire halfFlag;
  wire xferFlag;
  wire intFlag;
  wire [7:0] flagVector;
  wire [1:0] skipStep;
  wire [PC_WIDTH-1:0] stepTarget;
  wire [PC_WIDTH-1:0] skipTarget;
  wire [PC_WIDTH-1:0] branchTarget;
  wire opKnown;
  wire issue;
  wire needWait;

  csbu_compare_sub compareSub
  (
    .lhs(regA),
    .rhs(immValue),
    .diff(diff),
    .carry(subC),
    .half(subH),
    .overflow(subV),
    .zero(subZ),
    .negative(subN)
  );

  csbu_flag_select #(.WIDTH(8)) flagSelect
  (
    .flags(flagVector),
    .index(bitIndex),
    .wantSet(selSet),
    .hit(flagHit)
  );

  csbu_flag_select #(.WIDTH(8)) regBitSelect
  (
    .flags(regA),
    .index(bitIndex),
    .wantSet(1'b1),
    .hit(regBit)
  );

  csbu_flag_select #(.WIDTH(8)) ioBitSelect
  (
    .flags(ioValue),
    .index(bitIndex),
    .wantSet(1'b1),
    .hit(ioBit)
  );

  // status bits split out for the named branches
  // carry clear and carry set
  assign carryFlag = statusIn[`CSBU_FLAG_C];
  assign zeroFlag = statusIn[`CSBU_FLAG_Z];
  assign negFlag = statusIn[`CSBU_FLAG_N];
  assign ovfFlag = statusIn[`CSBU_FLAG_V];
  assign signFlag = statusIn[`CSBU_FLAG_S];
  assign halfFlag = statusIn[`CSBU_FLAG_H];
  assign xferFlag = statusIn[`CSBU_FLAG_T];
  // interrupt flag, reached by index only
  assign intFlag = statusIn[`CSBU_FLAG_I];
  assign flagVector = {intFlag, xferFlag, halfFlag, signFlag,
    ovfFlag, negFlag, zeroFlag, carryFlag};
  assign signedLess = negFlag ^ ovfFlag;
  assign offsetExt = {{(PC_WIDTH-7){branchOffset[6]}}, branchOffset};

  // fall-through, skip and branch addresses
  assign skipStep = nextIsTwoWord ? `CSBU_SKIP_LONG : `CSBU_SKIP_SHORT;
  assign stepTarget = pcIn + {{(PC_WIDTH-1){1'b0}}, 1'b1};
  assign skipTarget = pcIn + {{(PC_WIDTH-2){1'b0}}, skipStep};
  assign branchTarget = stepTarget + offsetExt;
  // only decoded opcodes start an instruction
  assign opKnown = next_pcLoad | next_flagsLoad;
  assign issue = opValid & opKnown;
  assign needWait = (next_waitCount != `CSBU_WAIT_NONE);

  // skip condition per opcode
  always @*
  begin
    skipHit = 1'b0;
    case (opCode)
      `CSBU_OP_CMPSKIP: skipHit = (regA == regB);
      `CSBU_OP_SKRC: skipHit = ~regBit;
      `CSBU_OP_SKRS: skipHit = regBit;
      `CSBU_OP_SKIC: skipHit = ~ioBit;
      `CSBU_OP_SKIS: skipHit = ioBit;
      default: skipHit = 1'b0;
    endcase
  end

  always @*
  begin
    selSet = (opCode == `CSBU_OP_BRFS);
    next_pcLoad = 1'b0;
    next_pcNext = stepTarget;
    next_flagsLoad = 1'b0;
    next_statusOut = statusIn;
    next_waitCount = `CSBU_WAIT_NONE;
    case (opCode)
      `CSBU_OP_CMPSKIP, `CSBU_OP_SKRC, `CSBU_OP_SKRS, `CSBU_OP_SKIC, `CSBU_OP_SKIS:
      begin
        next_pcLoad = 1'b1;
        if (skipHit)
        begin
          next_pcNext = skipTarget;
          next_waitCount = nextIsTwoWord ? `CSBU_WAIT_TWO : `CSBU_WAIT_ONE;
        end
      end
      `CSBU_OP_CMPI:
      begin
        next_pcLoad = 1'b1;
        next_flagsLoad = 1'b1;
        next_statusOut[`CSBU_FLAG_C] = subC;
        next_statusOut[`CSBU_FLAG_Z] = subZ;
        next_statusOut[`CSBU_FLAG_N] = subN;
        next_statusOut[`CSBU_FLAG_V] = subV;
        next_statusOut[`CSBU_FLAG_H] = subH;
        next_statusOut[`CSBU_FLAG_S] = subN ^ subV;
      end
      `CSBU_OP_BRFS, `CSBU_OP_BRFC:
      begin
        next_pcLoad = 1'b1;
        if (flagHit)
        begin
          next_pcNext = branchTarget;
          next_waitCount = `CSBU_WAIT_ONE;
        end
      end
      `CSBU_OP_SIGGE:
      begin
        next_pcLoad = 1'b1;
        if (!signedLess)
        begin
          next_pcNext = branchTarget;
          next_waitCount = `CSBU_WAIT_ONE;
        end
      end
      `CSBU_OP_SIGLT:
      begin
        next_pcLoad = 1'b1;
        if (signedLess)
        begin
          next_pcNext = branchTarget;
          next_waitCount = `CSBU_WAIT_ONE;
        end
      end
      default:
      begin
        next_pcLoad = 1'b0;
      end
    endcase
  end

  // issue, then hold busy for the extra cycles
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= `CSBU_ST_IDLE;
      waitCount <= 2'h0;
      busy <= 1'b0;
      pcLoad <= 1'b0;
      pcNext <= {PC_WIDTH{1'b0}};
      flagsLoad <= 1'b0;
      statusOut <= 8'h00;
      done <= 1'b0;
    end
    else if (clkEn)
    begin
      pcLoad <= 1'b0;
      flagsLoad <= 1'b0;
      done <= 1'b0;
      case (state)
        `CSBU_ST_IDLE:
        begin
          if (issue)
          begin
            pcLoad <= next_pcLoad;
            pcNext <= next_pcNext;
            flagsLoad <= next_flagsLoad;
            statusOut <= next_statusOut;
            if (needWait)
            begin
              waitCount <= next_waitCount;
              busy <= 1'b1;
              state <= `CSBU_ST_WAIT;
            end
            else
            begin
              done <= 1'b1;
            end
          end
        end
        `CSBU_ST_WAIT:
        begin
          waitCount <= waitCount - 2'h1;
          if (waitCount == `CSBU_WAIT_ONE)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= `CSBU_ST_IDLE;
          end
        end
        default:
        begin
          state <= `CSBU_ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: verification/csbu_unit_checker.sv
// assertions for the compare, skip and branch unit
`timescale 1ns/10ps
`include "csbu_defines.vh"
module csbu_unit_checker
#(
  parameter PC_WIDTH = 12
)
(
  input wire sys_clk,
  input wire reset_n,
  input wire clkEn,
  input wire opValid,
  input wire [3:0] opCode,
  input wire [7:0] regA,
  input wire [7:0] regB,
  input wire [2:0] bitIndex,
  input wire [6:0] branchOffset,
  input wire nextIsTwoWord,
  input wire [PC_WIDTH-1:0] pcIn,
  input wire [7:0] statusIn,
  input wire busy,
  input wire pcLoad,
  input wire [PC_WIDTH-1:0] pcNext,
  input wire flagsLoad,
  input wire done
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  wire start = clkEn && opValid && !busy && opCode != 4'h0 && opCode <= `CSBU_OP_SIGLT;
  wire hit = statusIn[bitIndex];
  wire sx = statusIn[2] ^ statusIn[3];
  wire [PC_WIDTH-1:0] target = pcIn + {{(PC_WIDTH-7){branchOffset[6]}}, branchOffset} + 1'b1;
  sequence extraOne;
    busy && !done ##1 done && !busy;
  endsequence
  sequence extraTwo;
    busy && !done ##1 busy && !done ##1 done && !busy;
  endsequence
  chk_start_load: assert property (start |=> pcLoad)
    else $error("accepted op gave no pc load");
  chk_cmp_flags: assert property (start && opCode == `CSBU_OP_CMPI |=> flagsLoad && done)
    else $error("compare immediate not one cycle");
  chk_no_flags: assert property (start && opCode != `CSBU_OP_CMPI |=> !flagsLoad)
    else $error("flags loaded by non compare");
  chk_brs_taken: assert property (start && opCode == `CSBU_OP_BRFS && hit
    |=> pcNext == $past(target) ##0 extraOne)
    else $error("flag set branch wrong");
  chk_brc_taken: assert property (start && opCode == `CSBU_OP_BRFC && !hit
    |=> pcNext == $past(target) ##0 extraOne)
    else $error("flag clear branch wrong");
  chk_br_untaken: assert property (start && (opCode == `CSBU_OP_BRFS && !hit
    || opCode == `CSBU_OP_BRFC && hit) |=> done && !busy)
    else $error("untaken branch not one cycle");
  chk_ge_taken: assert property (start && opCode == `CSBU_OP_SIGGE && !sx |=> extraOne)
    else $error("signed ge not taken");
  chk_lt_taken: assert property (start && opCode == `CSBU_OP_SIGLT && sx |=> extraOne)
    else $error("signed lt not taken");
  chk_skip_short: assert property (start && opCode == `CSBU_OP_SKRC && !regA[bitIndex]
    && !nextIsTwoWord |=> extraOne)
    else $error("short skip timing wrong");
  chk_skip_long: assert property (start && opCode == `CSBU_OP_CMPSKIP && regA == regB
    && nextIsTwoWord |=> extraTwo)
    else $error("long skip timing wrong");
endmodule
bind csbu_unit csbu_unit_checker #(.PC_WIDTH(PC_WIDTH)) u_csbu_unit_checker (.*);

// file: verification/tb.sv
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/10ps
`include "csbu_defines.vh"
module tb;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg clkEn = 1'b1;
  reg opValid = 1'b0;
  reg [3:0] opCode = 4'h0;
  reg [7:0] regA = 8'h00;
  reg [7:0] regB = 8'h00;
  reg [7:0] immValue = 8'h00;
  reg [7:0] ioValue = 8'h00;
  reg [2:0] bitIndex = 3'h0;
  reg [6:0] branchOffset = 7'h7E;
  reg nextIsTwoWord = 1'b0;
  reg [11:0] pcIn = 12'h100;
  reg [7:0] statusIn = 8'h55;
  wire busy, pcLoad, flagsLoad, done;
  wire [11:0] pcNext;
  wire [7:0] statusOut;
  integer badCount = 0;
  integer comparisons = 0;
  integer i;
  csbu_unit u_csbu_unit
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .opValid(opValid),
    .opCode(opCode),
    .regA(regA),
    .regB(regB),
    .immValue(immValue),
    .ioValue(ioValue),
    .bitIndex(bitIndex),
    .branchOffset(branchOffset),
    .nextIsTwoWord(nextIsTwoWord),
    .pcIn(pcIn),
    .statusIn(statusIn),
    .busy(busy),
    .pcLoad(pcLoad),
    .pcNext(pcNext),
    .flagsLoad(flagsLoad),
    .statusOut(statusOut),
    .done(done)
  );
  initial forever #10 sys_clk = ~sys_clk;
  task finish_test;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task check(input [79:0] name, input [15:0] seen, input [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      badCount = badCount + 1;
      $display("Error %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task run(input [3:0] op, input [11:0] expPc, input [15:0] lat);
    integer n;
  begin
    opValid = 1'b1;
    opCode = op;
    @(negedge sys_clk);
    check("pcLoad", pcLoad, 1'b1);
    check("pcNext", pcNext, expPc);
    check("busy", busy, lat > 16'h1);
    check("flagsLoad", flagsLoad, op == `CSBU_OP_CMPI);
    n = 1;
    while (done !== 1'b1 && n < 6)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    check("cycles", n[15:0], lat);
    if (n == 6)
      finish_test;
  end
  endtask
  task t_skip;
  begin
    regA = 8'h5A;
    regB = 8'h5A;
    ioValue = 8'h5A;
    run(`CSBU_OP_CMPSKIP, 12'h102, 2);
    nextIsTwoWord = 1'b1;
    run(`CSBU_OP_CMPSKIP, 12'h103, 3);
    regB = 8'h5B;
    run(`CSBU_OP_CMPSKIP, 12'h101, 1);
    nextIsTwoWord = 1'b0;
    for (i = 0; i < 8; i = i + 1)
    begin
      bitIndex = {2'b00, i[2]};
      run({2'b00, i[1:0]} + 4'h3, i[0] == i[2] ? 12'h102 : 12'h101, i[0] == i[2] ? 2 : 1);
    end
  end
  endtask
  task t_cmp(input [7:0] a, input [7:0] k);
    reg [7:0] d;
    reg v;
  begin
    regA = a;
    immValue = k;
    statusIn = 8'hC0;
    d = a - k;
    v = (a[7] & ~k[7] & ~d[7]) | (~a[7] & k[7] & d[7]);
    run(`CSBU_OP_CMPI, 12'h101, 1);
    check("flagsLoad", flagsLoad, 1'b1);
    check("statusOut", statusOut, {2'b11, (~a[3] & k[3]) | (k[3] & d[3]) | (d[3] & ~a[3]),
      d[7] ^ v, v, d[7], d == 8'h00, a < k});
  end
  endtask
  task t_branch;
  begin
    statusIn = 8'h55;
    for (i = 0; i < 16; i = i + 1)
    begin
      bitIndex = i[3:1];
      run(i[0] ? `CSBU_OP_BRFC : `CSBU_OP_BRFS, i[0] ^ ~i[1] ? 12'h0FF : 12'h101,
        i[0] ^ ~i[1] ? 2 : 1);
    end
    run(`CSBU_OP_SIGGE, 12'h101, 1);
    run(`CSBU_OP_SIGLT, 12'h0FF, 2);
    statusIn = 8'h0C;
    run(`CSBU_OP_SIGGE, 12'h0FF, 2);
    run(`CSBU_OP_SIGLT, 12'h101, 1);
  end
  endtask
  task t_refuse;
  begin
    for (i = 0; i < 3; i = i + 1)
    begin
      opCode = i == 0 ? 4'h0 : i == 1 ? 4'hB : `CSBU_OP_CMPSKIP;
      clkEn = i != 2;
      repeat (2) @(negedge sys_clk);
      check("pcLoad", pcLoad, 1'b0);
    end
    opValid = 1'b0;
    clkEn = 1'b1;
  end
  endtask
  initial
  begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    t_skip;
    t_cmp(8'h10, 8'h01);
    t_cmp(8'h80, 8'h01);
    t_cmp(8'h05, 8'h05);
    t_cmp(8'h00, 8'h01);
    t_branch;
    t_refuse;
    finish_test;
  end
endmodule
